//--- hw/core_decode_pkg.sv
/*
  Shared constants and types for the instruction decoder and the
  interrupt status block: register indices, bit positions, opcodes,
  cycle counts and the decoded instruction record.
  Assumes one instruction clock and AXI4-Lite register access.
*/
// Overview of operation
// - Low status: bits 4..0 flags, 7..5 unused
// - High status: bits 6..0 flags; watchdog debug-only
// - Flags latch the cycle after the event
// - Writing one never sets a flag
// - Supply-low flag follows level while enabled
// - Other sources are rising-edge triggered
// - Each 16-bit word decodes on its own
// - Direct 6-bit address reaches 0x00..0x3f
// - Indirect uses stored byte as pointer
// - Indirect form costs one extra cycle
// - File ops 0001,oooo,idff,ffff opcode nibbles
// - Destination bit one means file, else accumulator
// - Literal ops 0000,oooo,kkkk,kkkk one cycle
// - Bit ops 0011,ooib,bbff,ffff four kinds
// - Taken skip adds one cycle
// - Call 011 two cycles, jump 010 one
// - Far copies 10/11, two cycles each
// - Returns one cycle; fixed no-operation word
// - Flags affected per opcode within each class
// - Enabled pending flag calls vector, saves context
// - Interrupt return restores saved context
package core_decode_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS_LOW = 6'h06;
  localparam logic [5:0] IDX_ENABLE_LOW = 6'h07;
  localparam logic [5:0] IDX_STATUS_HIGH = 6'h08;
  localparam logic [5:0] IDX_ENABLE_HIGH = 6'h09;
  localparam logic [5:0] IDX_CORE_CTRL = 6'h0a;
  localparam logic [5:0] IDX_DECODE_INFO = 6'h0b;

  // Status layout
  localparam logic [7:0] LOW_USED_MASK = 8'h1f;
  localparam logic [7:0] HIGH_USED_MASK = 8'h7f;
  localparam int BIT_SUPPLY_LOW = 4;
  localparam int BIT_WATCHDOG = 6;
  localparam int BIT_GLOBAL_ENABLE = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h17fe;
  localparam logic [5:0] LAST_REG_ADDR = 6'h17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Opcode nibbles, file group
  localparam logic [3:0] F_ADD = 4'h0, F_AND = 4'h1, F_CLR = 4'h2, F_COM = 4'h3;
  localparam logic [3:0] F_DEC = 4'h4, F_DECSZ = 4'h5, F_INC = 4'h6, F_INCSZ = 4'h7;
  localparam logic [3:0] F_LOAD = 4'h8, F_OR = 4'h9, F_STORE = 4'hb, F_ROTL = 4'hc;
  // Opcode nibbles, literal and return group
  localparam logic [3:0] L_AND = 4'h8, L_OR = 4'h9, L_LOAD = 4'ha, L_ADD = 4'hc;
  localparam logic [3:0] L_RETLIT = 4'h5, L_RET = 4'h7, L_IRET = 4'h4, L_NOP = 4'h1;
  localparam logic [7:0] NOP_LOW = 8'h01;
  localparam logic [7:0] ZERO_LOW = 8'h00;

  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;

  // Flags affected mask {carry, digit carry, zero}
  localparam logic [2:0] FL_NONE = 3'b000;
  localparam logic [2:0] FL_Z = 3'b001;
  localparam logic [2:0] FL_C = 3'b100;
  localparam logic [2:0] FL_CDZ = 3'b111;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0, CLS_FILE = 4'h1, CLS_LIT = 4'h2, CLS_BIT = 4'h3,
    CLS_JUMP = 4'h4, CLS_CALL = 4'h5, CLS_FAR_TO_NEAR = 4'h6,
    CLS_NEAR_TO_FAR = 4'h7, CLS_RET = 4'h8, CLS_RETLIT = 4'h9,
    CLS_IRET = 4'ha, CLS_ILLEGAL = 4'hf
  } op_class_t;

  typedef enum logic [0:0] {
    IRQ_IDLE = 1'b0,
    IRQ_SERVICE = 1'b1
  } irq_state_t;

  // One decoded instruction
  typedef struct packed {
    logic valid;
    op_class_t op_class;
    logic [3:0] opcode;
    logic indirect;
    logic dest_file;
    logic [5:0] near_addr;
    logic reg_space;
    logic [7:0] literal;
    logic [2:0] bit_idx;
    logic [12:0] target;
    logic [1:0] cycles;
    logic [1:0] cycles_skip;
    logic is_skip;
    logic [2:0] flags_mask;
  } decode_t;

  // Peripheral event lines
  typedef struct packed {
    logic [4:0] low;
    logic [6:0] high;
  } irq_events_t;

endpackage

//--- hw/risc_core_decode.sv
/*
  Instruction decoder with the two interrupt status registers and the
  interrupt entry/return sequencing, behind an AXI4-Lite slave.
  Assumes instruction words and peripheral events come from logic on
  the same clock, and that the core executes what it is handed.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module risc_core_decode
  import core_decode_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Program memory side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output decode_t decoded,
  // Core context
  input wire logic [12:0] pc_now,
  input wire logic [2:0] flags_now,
  output logic irq_call,
  output logic [12:0] irq_target,
  output logic ctx_restore,
  output logic [12:0] restore_pc,
  output logic [2:0] restore_flags,
  // Peripheral events
  input wire irq_events_t events,
  input wire logic debug_mode
);

  // Index decode reads address bits 7..2, so narrower buses cannot work
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("ADDR_WIDTH must be 8 to 32");
  end

  // Instruction decode, purely from the fetched word
  decode_t dec_next, dec_reg;
  logic [3:0] nib;
  always_comb begin
    nib = instr_word[11:8];
    dec_next = '0;
    dec_next.valid = instr_valid;
    dec_next.opcode = nib;
    dec_next.indirect = instr_word[7];
    dec_next.dest_file = instr_word[6];
    dec_next.near_addr = instr_word[5:0];
    dec_next.reg_space = (instr_word[5:0] <= LAST_REG_ADDR);
    dec_next.literal = instr_word[7:0];
    dec_next.bit_idx = instr_word[8:6];
    dec_next.target = instr_word[12:0];
    dec_next.cycles = CYC_ONE;
    dec_next.flags_mask = FL_NONE;
    dec_next.op_class = CLS_ILLEGAL;
    if (instr_word[15]) begin
      // Far copies keep the far byte in bits 13..6
      dec_next.op_class = instr_word[14] ? CLS_NEAR_TO_FAR : CLS_FAR_TO_NEAR;
      dec_next.literal = instr_word[13:6];
      dec_next.indirect = 1'b0;
      dec_next.cycles = CYC_TWO;
    end else if (instr_word[14]) begin
      // Branches
      dec_next.indirect = 1'b0;
      if (instr_word[13]) begin
        dec_next.op_class = CLS_CALL;
        dec_next.cycles = CYC_TWO;
      end else begin
        dec_next.op_class = CLS_JUMP;
      end
    end else begin
      case (instr_word[13:12])
        2'b11: begin
          // Bit group: op in 11..10, index in 8..6
          dec_next.op_class = CLS_BIT;
          dec_next.opcode = {2'b00, instr_word[11:10]};
          dec_next.indirect = instr_word[9];
          dec_next.dest_file = 1'b1;
          dec_next.is_skip = instr_word[11];
          dec_next.cycles = instr_word[9] ? CYC_TWO : CYC_ONE;
        end
        2'b01: begin
          // File group
          dec_next.op_class = CLS_FILE;
          dec_next.cycles = instr_word[7] ? CYC_TWO : CYC_ONE;
          case (nib)
            F_ADD: dec_next.flags_mask = FL_CDZ;
            F_AND, F_COM, F_DEC, F_INC, F_OR: dec_next.flags_mask = FL_Z;
            F_CLR, F_LOAD: dec_next.flags_mask = FL_Z;
            F_ROTL: dec_next.flags_mask = FL_C;
            F_DECSZ, F_INCSZ: dec_next.is_skip = 1'b1;
            F_STORE: dec_next.dest_file = 1'b1;
            default: dec_next.op_class = CLS_ILLEGAL;
          endcase
        end
        2'b00: begin
          // Literal and return group
          dec_next.indirect = 1'b0;
          dec_next.dest_file = 1'b0;
          case (nib)
            L_AND, L_OR: begin
              dec_next.op_class = CLS_LIT;
              dec_next.flags_mask = FL_Z;
            end
            L_ADD: begin
              dec_next.op_class = CLS_LIT;
              dec_next.flags_mask = FL_CDZ;
            end
            L_LOAD: dec_next.op_class = CLS_LIT;
            L_RETLIT: dec_next.op_class = CLS_RETLIT;
            L_RET: begin
              if (instr_word[7:0] == ZERO_LOW) begin
                dec_next.op_class = CLS_RET;
              end
            end
            L_IRET: begin
              if (instr_word[7:0] == ZERO_LOW) begin
                dec_next.op_class = CLS_IRET;
              end
            end
            L_NOP: begin
              if (instr_word[7:0] == NOP_LOW) begin
                dec_next.op_class = CLS_NOP;
              end
            end
            default: dec_next.op_class = CLS_ILLEGAL;
          endcase
        end
        default: dec_next.op_class = CLS_ILLEGAL;
      endcase
    end
    // A taken skip costs one more cycle
    dec_next.cycles_skip = dec_next.is_skip ? 2'(dec_next.cycles + CYC_ONE) : dec_next.cycles;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end
  assign decoded = dec_reg;

  // Register bus: address and data may arrive in either order
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [5:0] aw_idx_reg, aw_idx_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wlane_reg, wlane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic wr_fire;
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    aw_idx_next = aw_idx_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      aw_idx_next = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (aw_idx_reg >= IDX_STATUS_LOW && aw_idx_reg <= IDX_DECODE_INFO)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_idx_reg <= aw_idx_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Write strobes per register; byte lane 0 carries all data
  logic wr_slow, wr_shigh, wr_elow, wr_ehigh, wr_ctrl;
  assign wr_slow = wr_fire && wlane_reg && aw_idx_reg == IDX_STATUS_LOW;
  assign wr_shigh = wr_fire && wlane_reg && aw_idx_reg == IDX_STATUS_HIGH;
  assign wr_elow = wr_fire && wlane_reg && aw_idx_reg == IDX_ENABLE_LOW;
  assign wr_ehigh = wr_fire && wlane_reg && aw_idx_reg == IDX_ENABLE_HIGH;
  assign wr_ctrl = wr_fire && wlane_reg && aw_idx_reg == IDX_CORE_CTRL;

  // Status flags: edge-detected events, level supply-low, set beats clear
  logic [7:0] stat_low_reg, stat_low_next, stat_high_reg, stat_high_next;
  logic [7:0] en_low_reg, en_low_next, en_high_reg, en_high_next;
  logic [7:0] ctrl_reg, ctrl_next;
  irq_events_t ev_prev_reg;
  logic [7:0] set_low, set_high, keep_low, keep_high;
  always_comb begin
    // Edge sources set once per rising edge
    set_low = {3'b000, events.low & ~ev_prev_reg.low} & LOW_USED_MASK;
    set_high = {1'b0, events.high & ~ev_prev_reg.high} & HIGH_USED_MASK;
    // Supply-low follows its level while enabled
    set_high[BIT_SUPPLY_LOW] = events.high[BIT_SUPPLY_LOW] && en_high_reg[BIT_SUPPLY_LOW];
    // Watchdog counts only while debugging
    set_high[BIT_WATCHDOG] = set_high[BIT_WATCHDOG] && debug_mode;
    // Write zero clears, write one leaves the bit alone
    keep_low = wr_slow ? wbyte_reg : 8'hff;
    keep_high = wr_shigh ? wbyte_reg : 8'hff;
    // Next-cycle latch; unused bits forced low
    stat_low_next = ((stat_low_reg & keep_low) | set_low) & LOW_USED_MASK;
    stat_high_next = ((stat_high_reg & keep_high) | set_high) & HIGH_USED_MASK;
    en_low_next = wr_elow ? (wbyte_reg & LOW_USED_MASK) : en_low_reg;
    en_high_next = wr_ehigh ? (wbyte_reg & HIGH_USED_MASK) : en_high_reg;
    ctrl_next = wr_ctrl ? {7'h00, wbyte_reg[BIT_GLOBAL_ENABLE]} : ctrl_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_low_reg <= STATUS_RESET;
      stat_high_reg <= STATUS_RESET;
      en_low_reg <= STATUS_RESET;
      en_high_reg <= STATUS_RESET;
      ctrl_reg <= STATUS_RESET;
      ev_prev_reg <= '0;
    end else begin
      stat_low_reg <= stat_low_next;
      stat_high_reg <= stat_high_next;
      en_low_reg <= en_low_next;
      en_high_reg <= en_high_next;
      ctrl_reg <= ctrl_next;
      ev_prev_reg <= events;
    end
  end

  // Interrupt entry and return; no nesting, so one shadow suffices
  irq_state_t irq_state_reg, irq_state_next;
  logic [12:0] shadow_pc_reg, shadow_pc_next;
  logic [2:0] shadow_fl_reg, shadow_fl_next;
  logic call_reg, call_next, restore_reg, restore_next;
  logic pending;
  assign pending = |(stat_low_reg & en_low_reg) || |(stat_high_reg & en_high_reg);
  always_comb begin
    irq_state_next = irq_state_reg;
    shadow_pc_next = shadow_pc_reg;
    shadow_fl_next = shadow_fl_reg;
    call_next = 1'b0;
    restore_next = 1'b0;
    case (irq_state_reg)
      IRQ_IDLE: begin
        if (pending && ctrl_reg[BIT_GLOBAL_ENABLE]) begin
          // Save pc and flags, never the accumulator
          irq_state_next = IRQ_SERVICE;
          shadow_pc_next = pc_now;
          shadow_fl_next = flags_now;
          call_next = 1'b1;
        end
      end
      IRQ_SERVICE: begin
        if (dec_reg.valid && dec_reg.op_class == CLS_IRET) begin
          irq_state_next = IRQ_IDLE;
          restore_next = 1'b1;
        end
      end
      default: irq_state_next = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_state_reg <= IRQ_IDLE;
      shadow_pc_reg <= 13'h0000;
      shadow_fl_reg <= 3'b000;
      call_reg <= 1'b0;
      restore_reg <= 1'b0;
    end else begin
      irq_state_reg <= irq_state_next;
      shadow_pc_reg <= shadow_pc_next;
      shadow_fl_reg <= shadow_fl_next;
      call_reg <= call_next;
      restore_reg <= restore_next;
    end
  end
  assign irq_call = call_reg;
  assign irq_target = IRQ_VECTOR;
  assign ctx_restore = restore_reg;
  assign restore_pc = shadow_pc_reg;
  assign restore_flags = shadow_fl_reg;

  // Read channel: one outstanding read, answer one cycle after address
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr[7:2])
        IDX_STATUS_LOW: rdata_next = {24'h000000, stat_low_reg};
        IDX_ENABLE_LOW: rdata_next = {24'h000000, en_low_reg};
        IDX_STATUS_HIGH: rdata_next = {24'h000000, stat_high_reg};
        IDX_ENABLE_HIGH: rdata_next = {24'h000000, en_high_reg};
        IDX_CORE_CTRL: rdata_next = {23'h000000, irq_state_reg, ctrl_reg};
        IDX_DECODE_INFO: rdata_next = {16'h0000, dec_reg.cycles_skip, dec_reg.cycles,
                                       dec_reg.flags_mask, dec_reg.is_skip,
                                       dec_reg.op_class, dec_reg.indirect,
                                       dec_reg.dest_file, dec_reg.valid, 1'b0};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Checks on status layout, latching, decode timing and context
  property p_low_unused;
    @(posedge aclk) disable iff (!aresetn) stat_low_reg[7:5] == 3'b000;
  endproperty
  a_low_unused: assert property (p_low_unused) else $error("low status unused set");

  property p_high_unused;
    @(posedge aclk) disable iff (!aresetn) stat_high_reg[7] == 1'b0;
  endproperty
  a_high_unused: assert property (p_high_unused) else $error("high status bit 7 set");

  property p_latch_next;
    @(posedge aclk) disable iff (!aresetn)
      (events.low[0] && !ev_prev_reg.low[0]) |=> stat_low_reg[0];
  endproperty
  a_latch_next: assert property (p_latch_next) else $error("flag not latched next");

  property p_write_one;
    @(posedge aclk) disable iff (!aresetn)
      (!stat_low_reg[1] && !set_low[1] && wr_slow) |=> !stat_low_reg[1];
  endproperty
  a_write_one: assert property (p_write_one) else $error("write set a flag");

  property p_level;
    @(posedge aclk) disable iff (!aresetn)
      (events.high[BIT_SUPPLY_LOW] && en_high_reg[BIT_SUPPLY_LOW])
        |=> stat_high_reg[BIT_SUPPLY_LOW];
  endproperty
  a_level: assert property (p_level) else $error("supply-low not held");

  property p_edge_only;
    @(posedge aclk) disable iff (!aresetn)
      $rose(stat_low_reg[2]) |-> $past(events.low[2]) && !$past(ev_prev_reg.low[2]);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("flag set without edge");

  property p_indirect;
    @(posedge aclk) disable iff (!aresetn)
      (instr_valid && instr_word[15:12] == 4'h1 && instr_word[7]) |=> dec_reg.cycles == 2'd2;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect not two cycles");

  property p_skip;
    @(posedge aclk) disable iff (!aresetn)
      dec_reg.is_skip |-> dec_reg.cycles_skip == dec_reg.cycles + 2'd1;
  endproperty
  a_skip: assert property (p_skip) else $error("skip cost wrong");

  property p_branch;
    @(posedge aclk) disable iff (!aresetn)
      (instr_valid && instr_word[15:14] == 2'b01)
        |=> dec_reg.cycles == (dec_reg.op_class == CLS_CALL ? 2'd2 : 2'd1);
  endproperty
  a_branch: assert property (p_branch) else $error("branch cycles wrong");

  property p_add_flags;
    @(posedge aclk) disable iff (!aresetn)
      (instr_valid && instr_word[15:8] == 8'h0c) |=> dec_reg.flags_mask == 3'b111;
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_call_ctx;
    @(posedge aclk) disable iff (!aresetn)
      irq_call |-> shadow_pc_reg == $past(pc_now) && irq_target == 13'h17fe;
  endproperty
  a_call_ctx: assert property (p_call_ctx) else $error("context not saved");

  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
      ctx_restore |-> $past(dec_reg.op_class) == CLS_IRET && restore_pc == $past(shadow_pc_reg);
  endproperty
  a_restore: assert property (p_restore) else $error("bad restore");

  c_irq_round: cover property (@(posedge aclk) disable iff (!aresetn)
    irq_call ##[1:50] ctx_restore);
  c_clear_flag: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(stat_high_reg[2]));
  c_skip_indirect: cover property (@(posedge aclk) disable iff (!aresetn)
    dec_reg.is_skip && dec_reg.indirect);

endmodule

//--- verification/periph_model.sv
/*
  Peripheral model: event levels set by the bench, plus one
  discharge-fault peripheral with its own fault flag.
  Assumes inputs change just after rising edges.
*/
`timescale 1ns/1ns
module periph_model
  import core_decode_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic [11:0] lvl,
  input wire logic fault_set,
  input wire logic fault_clr,
  // Event lines
  output irq_events_t events
);
  logic discharge_fault_flag;

  // Fault holds its line up until software clears it first
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_clr)
      discharge_fault_flag <= 1'b0;
    else if (fault_set)
      discharge_fault_flag <= 1'b1;
  end

  // Plain levels; supply-low stays up as long as bench holds it
  assign events = irq_events_t'(lvl | {9'h000, discharge_fault_flag, 2'h0});
endmodule

//--- verification/risc_core_decode_and_irq_status_bench.sv
/*
  Bench for the decoder and interrupt status block.
  Assumes the package and the peripheral model are compiled first.
*/
`timescale 1ns/1ns
module risc_core_decode_and_irq_status_bench
  import core_decode_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic instr_valid, irq_call, ctx_restore, debug_mode, fault_set, fault_clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] instr_word;
  logic [12:0] pc_now, irq_target, restore_pc;
  logic [2:0] flags_now, restore_flags;
  logic [11:0] lvl;
  decode_t decoded;
  irq_events_t events;
  int n_errors, checked, cyc;
  // Words and expected {class, cycles, flags}
  logic [15:0] dw [19] = '{16'h1000, 16'h10bf, 16'h1c40, 16'h1b00, 16'h1240, 16'h0c55,
    16'h0855, 16'h3b80, 16'h7abc, 16'h4123, 16'h8123, 16'hc123, 16'h0700, 16'h0400,
    16'h0512, 16'h0101, 16'h1580, 16'h0a33, 16'h0b00};
  logic [8:0] de [19] = '{9'h02f, 9'h037, 9'h02c, 9'h028, 9'h029, 9'h04f, 9'h049, 9'h070,
    9'h0b0, 9'h088, 9'h0d0, 9'h0f0, 9'h108, 9'h148, 9'h128, 9'h008, 9'h030, 9'h048,
    9'h1e8};

  risc_core_decode dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .instr_valid(instr_valid), .instr_word(instr_word), .decoded(decoded),
    .pc_now(pc_now), .flags_now(flags_now), .irq_call(irq_call), .irq_target(irq_target),
    .ctx_restore(ctx_restore), .restore_pc(restore_pc), .restore_flags(restore_flags),
    .events(events), .debug_mode(debug_mode));

  periph_model partner (.aclk(aclk), .aresetn(aresetn), .lvl(lvl), .fault_set(fault_set),
    .fault_clr(fault_clr), .events(events));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  // Write: each channel released as soon as it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'b11;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask

  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    rdr(a);
    chk(s, e, rd);
  endtask

  task automatic t_edges;
    rc(8'h18, 32'h0, "low_reset");
    rc(8'h20, 32'h0, "high_reset");
    rdr(8'h3c);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rr));
    debug_mode <= 1'b1;
    lvl <= 12'hfef;
    @(posedge aclk);
    rc(8'h18, 32'h1f, "low_set");
    rc(8'h20, 32'h6f, "high_set");
    wr(8'h18, 32'hff);
    chk("wr_okay", 32'(RESP_OKAY), 32'(bresp));
    rc(8'h18, 32'h1f, "ones_kept");
    wr(8'h3c, 32'h0);
    chk("wr_unmapped", 32'(RESP_SLVERR), 32'(bresp));
    wr(8'h18, 32'h0);
    wr(8'h20, 32'h0);
    rc(8'h18, 32'h0, "low_held");
    rc(8'h20, 32'h0, "high_held");
    {debug_mode, lvl} <= 13'h0;
    @(posedge aclk);
    lvl <= 12'h040;
    @(posedge aclk);
    rc(8'h20, 32'h0, "wdg_off");
    lvl <= 12'h0;
    $display("edge test done");
  endtask

  task automatic t_level;
    wr(8'h24, 32'h10);
    lvl <= 12'h010;
    wr(8'h20, 32'h0);
    rc(8'h20, 32'h10, "supply_held");
    lvl <= 12'h0;
    wr(8'h20, 32'h0);
    rc(8'h20, 32'h0, "supply_gone");
    wr(8'h24, 32'h0);
    $display("level test done");
  endtask

  task automatic t_decode;
    instr_valid <= 1'b1;
    for (int i = 0; i < 19; i++) begin
      instr_word <= dw[i];
      repeat (2) @(posedge aclk);
      chk("decode", 32'(de[i]), 32'({decoded.op_class, decoded.cycles, decoded.flags_mask}));
      if (i == 1)
        chk("addr", 32'h13f, 32'({decoded.indirect, decoded.dest_file, decoded.reg_space, decoded.near_addr}));
      if (i == 2)
        chk("dest", 32'h0c0, 32'({decoded.indirect, decoded.dest_file, decoded.reg_space, decoded.near_addr}));
      if (i == 7 || i == 16)
        chk("skip", 32'h3e, 32'({decoded.is_skip, decoded.cycles_skip, decoded.bit_idx}));
      if (i == 8)
        chk("target", 32'h1abc, 32'(decoded.target));
      if (i == 10)
        chk("far", 32'h123, 32'({decoded.literal, decoded.near_addr}));
    end
    $display("decode test done");
  endtask

  task automatic t_irq;
    pc_now <= 13'h0123;
    flags_now <= 3'b101;
    wr(8'h24, 32'h04);
    wr(8'h28, 32'h01);
    fault_set <= 1'b1;
    do @(posedge aclk); while (!irq_call);
    fault_set <= 1'b0;
    chk("vector", 32'(IRQ_VECTOR), 32'(irq_target));
    rc(8'h28, 32'h101, "in_service");
    fault_clr <= 1'b1;
    wr(8'h20, 32'h0);
    fault_clr <= 1'b0;
    {pc_now, flags_now} <= 16'h0;
    instr_word <= 16'h0400;
    do @(posedge aclk); while (!ctx_restore);
    chk("restore", 32'h091d, 32'({restore_pc, restore_flags}));
    instr_word <= 16'h0101;
    $display("interrupt test done");
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test;
    end
  end

  initial begin
    {awvalid, wvalid, arvalid, instr_valid, debug_mode, fault_set, fault_clr} = 7'h0;
    {awaddr, araddr, wdata, instr_word, pc_now, flags_now, lvl} = 92'h0;
    {aresetn, n_errors, checked, cyc} = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_edges;
    t_level;
    t_decode;
    t_irq;
    stop_test;
  end
endmodule
